// ---- common/sirq_pkg.sv ----
// Shared constants and types for the serial interrupt and clock-run block
package sirq_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_COMMAND      = 8'h04;
  localparam logic [7:0] OFS_BRIDGE_CTRL  = 8'h3E;
  localparam logic [7:0] OFS_MSI_CONTROL  = 8'h52;
  localparam logic [7:0] OFS_MSI_ADDR_LO  = 8'h54;
  localparam logic [7:0] OFS_MSI_ADDR_HI  = 8'h58;
  localparam logic [7:0] OFS_MSI_DATA     = 8'h5C;
  localparam logic [7:0] OFS_CLK_RUN_STAT = 8'hDA;
  localparam logic [7:0] OFS_SIRQ_FORMAT  = 8'hE0;
  localparam logic [7:0] OFS_SIRQ_EDGE    = 8'hE2;
  localparam logic [7:0] OFS_SIRQ_STATE   = 8'hE4;

  // ==========================================================
  // Field positions and fixed field values
  localparam int         CMD_MASTER_BIT   = 2;
  localparam int         BRC_SECONDARY_RESET_CONTROL_BIT     = 6;
  localparam int         SINGLE_MESSAGE_ENABLE_BIT       = 0;
  localparam int         MMC_LSB          = 4;
  localparam int         MMC_MSB          = 6;
  localparam int         CRS_RUN_BIT      = 0;
  localparam int         SIF_ENABLE_BIT   = 0;
  localparam logic [2:0] MSI_MMC_CAP      = 3'h4;
  localparam logic       MSI_CAP_64       = 1'b1;

  // ==========================================================
  // Serial frame timing, in bus clock edges
  localparam int         IRQ_COUNT        = 16;
  localparam logic [4:0] FRAME_COUNT      = 5'h11;
  localparam logic [4:0] CHECK_FRAME      = 5'h10;
  localparam logic [1:0] LAST_PHASE       = 2'h2;
  localparam logic [2:0] START_CLKS       = 3'h4;
  localparam logic [2:0] STOP_CLKS        = 3'h2;
  localparam logic [9:0] CLK_RUN_MIN      = 10'h200;

  // Synchroniser layout of the pin group
  localparam int         SYNC_W           = 8;
  localparam logic [7:0] SYNC_IDLE        = 8'hFF;

  typedef enum logic [2:0] {
    SIRQ_IDLE     = 3'b000,
    SIRQ_START    = 3'b001,
    SIRQ_RECOVER  = 3'b010,
    SIRQ_TURN     = 3'b011,
    SIRQ_FRAME    = 3'b100,
    SIRQ_STOP     = 3'b101,
    SIRQ_STOP_REC = 3'b110
  } sirq_state_t;

endpackage

// ---- hdl/sirq_sync.sv ----
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps

module sirq_sync #(
  parameter int             W         = 8,
  parameter logic [W-1:0]   IDLE_VAL  = '1
) (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      meta_reg <= IDLE_VAL;
      sync_out <= IDLE_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// ---- hdl/sirq_top.sv ----
// Serial interrupt to message converter with clock-run central resource
`timescale 1ns/1ps

// Functional notes
// - Frame stream has seventeen frames on bus clock
// - Only IRQ0..IRQ15 decoded, check frame ignored
// - Edge mode: message on sampled rising level
// - Level mode: message on status bit rising
// - Edge control register picks edge or level
// - Format register sets serial bus operation
// - Status register shows per-frame interrupt state
// - Enable bit and count field select messages
// - Message number is interrupt modulo count
// - Messages sent only with bus mastering allowed
// - High address nonzero selects 64-bit address
// - Message data register gives system value
// - Payload bytes 0,1 carry value and number
// - Strap high makes pin zero clock request
// - Acts only as clock-run master
// - Sideband lines still tracked with clocks stopped
// - Request keeps clocks running 512 cycles minimum
// - Pending interrupt keeps clocks until cleared
// - Downstream traffic asserts request when stopped
// - Secondary reset resets clock-run, clocks run
// - Status bit 0 shows clocks running
// - Reset control bit drives secondary reset
module sirq_top (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  input  wire logic        pci_clk_in,
  input  wire logic        serial_interrupt_line_in,
  output logic             serial_interrupt_line_out,
  output logic             serial_interrupt_line_oe,
  input  wire logic        general_pin_zero_in,
  output logic             general_pin_zero_out,
  output logic             general_pin_zero_oe,
  input  wire logic        clock_request_strap,
  input  wire logic [3:0]  intx_n,
  input  wire logic        ds_txn_req,
  output logic             secondary_clock_running,
  output logic             secondary_bus_reset_n,
  output logic             msi_req_valid,
  input  wire logic        msi_req_ready,
  output logic      [63:0] msi_addr,
  output logic             msi_is_64,
  output logic      [31:0] msi_payload,
  output logic      [3:0]  intx_change,
  output logic      [3:0]  intx_asserted
);

  // ==========================================================
  // Helpers
  function automatic logic [3:0] msg_mask(input logic [2:0] mmc);
    case (mmc)
      3'h0:    msg_mask = 4'h0;
      3'h1:    msg_mask = 4'h1;
      3'h2:    msg_mask = 4'h3;
      3'h3:    msg_mask = 4'h7;
      default: msg_mask = 4'hF;
    endcase
  endfunction

  function automatic logic [3:0] first_one(input logic [15:0] v);
    first_one = 4'h0;
    for (int i = sirq_pkg::IRQ_COUNT - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_one = i[3:0];
      end
    end
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic [7:0] sync_out;
  logic       pci_clk_s;
  logic       line_s;
  logic       gp0_s;
  logic       strap_s;
  logic [3:0] intx_s;

  sirq_sync #(
    .W        (sirq_pkg::SYNC_W),
    .IDLE_VAL (sirq_pkg::SYNC_IDLE)
  ) u_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in ({pci_clk_in, serial_interrupt_line_in,
                general_pin_zero_in, clock_request_strap, intx_n}),
    .sync_out (sync_out)
  );

  assign {pci_clk_s, line_s, gp0_s, strap_s, intx_s} = sync_out;

  logic pci_prev_reg;
  logic pci_rise;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pci_prev_reg <= 1'b1;
    end else begin
      pci_prev_reg <= pci_clk_s;
    end
  end

  assign pci_rise = pci_clk_s & ~pci_prev_reg;

  // ==========================================================
  // Configuration registers
  logic        master_reg;
  logic        secondary_reset_control_reg;
  logic        single_message_enable_reg;
  logic [2:0]  mmc_reg;
  logic [31:0] addr_lo_reg;
  logic [31:0] addr_hi_reg;
  logic [15:0] msg_data_reg;
  logic [7:0]  format_reg;
  logic [15:0] edge_reg;
  logic [15:0] state_reg;
  logic [15:0] state_set;
  logic        clk_run_reg;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      master_reg   <= 1'b0;
      secondary_reset_control_reg     <= 1'b0;
      single_message_enable_reg   <= 1'b0;
      mmc_reg      <= 3'h0;
      addr_lo_reg  <= 32'h0000_0000;
      addr_hi_reg  <= 32'h0000_0000;
      msg_data_reg <= 16'h0000;
      format_reg   <= 8'h00;
      edge_reg     <= 16'h0000;
    end else if (cfg_wr) begin
      case (cfg_addr)
        sirq_pkg::OFS_COMMAND:
          master_reg <= cfg_wdata[sirq_pkg::CMD_MASTER_BIT];
        sirq_pkg::OFS_BRIDGE_CTRL:
          secondary_reset_control_reg <= cfg_wdata[sirq_pkg::BRC_SECONDARY_RESET_CONTROL_BIT];
        sirq_pkg::OFS_MSI_CONTROL: begin
          single_message_enable_reg <= cfg_wdata[sirq_pkg::SINGLE_MESSAGE_ENABLE_BIT];
          // Counts above the capability clamp to sixteen
          mmc_reg    <= (cfg_wdata[sirq_pkg::MMC_MSB:sirq_pkg::MMC_LSB] >
                         sirq_pkg::MSI_MMC_CAP) ? sirq_pkg::MSI_MMC_CAP :
                        cfg_wdata[sirq_pkg::MMC_MSB:sirq_pkg::MMC_LSB];
        end
        sirq_pkg::OFS_MSI_ADDR_LO: addr_lo_reg  <= cfg_wdata;
        sirq_pkg::OFS_MSI_ADDR_HI: addr_hi_reg  <= cfg_wdata;
        sirq_pkg::OFS_MSI_DATA:    msg_data_reg <= cfg_wdata[15:0];
        sirq_pkg::OFS_SIRQ_FORMAT: format_reg   <= cfg_wdata[7:0];
        sirq_pkg::OFS_SIRQ_EDGE:   edge_reg     <= cfg_wdata[15:0];
        default: ;
      endcase
    end
  end

  // Set wins over the write-one-to-clear
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg <= 16'h0000;
    end else if (cfg_wr && cfg_addr == sirq_pkg::OFS_SIRQ_STATE) begin
      state_reg <= (state_reg & ~cfg_wdata[15:0]) | state_set;
    end else begin
      state_reg <= state_reg | state_set;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cfg_rdata <= 32'h0000_0000;
    end else if (cfg_rd) begin
      case (cfg_addr)
        sirq_pkg::OFS_COMMAND:
          cfg_rdata <= {29'h0, master_reg, 2'h0};
        sirq_pkg::OFS_BRIDGE_CTRL:
          cfg_rdata <= {25'h0, secondary_reset_control_reg, 6'h00};
        sirq_pkg::OFS_MSI_CONTROL:
          cfg_rdata <= {24'h0, sirq_pkg::MSI_CAP_64, mmc_reg,
                        sirq_pkg::MSI_MMC_CAP, single_message_enable_reg};
        sirq_pkg::OFS_MSI_ADDR_LO:  cfg_rdata <= addr_lo_reg;
        sirq_pkg::OFS_MSI_ADDR_HI:  cfg_rdata <= addr_hi_reg;
        sirq_pkg::OFS_MSI_DATA:     cfg_rdata <= {16'h0, msg_data_reg};
        sirq_pkg::OFS_CLK_RUN_STAT:
          cfg_rdata <= {31'h0, clk_run_reg};
        sirq_pkg::OFS_SIRQ_FORMAT:  cfg_rdata <= {24'h0, format_reg};
        sirq_pkg::OFS_SIRQ_EDGE:    cfg_rdata <= {16'h0, edge_reg};
        sirq_pkg::OFS_SIRQ_STATE:   cfg_rdata <= {16'h0, state_reg};
        default:                    cfg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // Secondary bus reset pin, active low on the wire
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      secondary_bus_reset_n <= 1'b1;
    end else begin
      secondary_bus_reset_n <= ~secondary_reset_control_reg;
    end
  end

  // ==========================================================
  // Serial frame engine, advanced on bus clock rising edges
  sirq_pkg::sirq_state_t st_reg;
  logic [2:0]  cnt_reg;
  logic [1:0]  phase_reg;
  logic [4:0]  frame_reg;
  logic [9:0]  run_cnt_reg;
  logic        strap_reg;
  logic        sample_pulse;
  logic        cycle_wanted;

  // A cycle starts only while something keeps the bus clocks alive
  assign cycle_wanted = format_reg[sirq_pkg::SIF_ENABLE_BIT] & clk_run_reg &
                        (~strap_reg | (run_cnt_reg != 10'h000) |
                         (|state_reg));

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_reg    <= sirq_pkg::SIRQ_IDLE;
      cnt_reg   <= 3'h0;
      phase_reg <= 2'h0;
      frame_reg <= 5'h00;
    end else if (pci_rise) begin
      case (st_reg)
        sirq_pkg::SIRQ_IDLE: begin
          cnt_reg <= 3'h1;
          if (cycle_wanted) begin
            st_reg <= sirq_pkg::SIRQ_START;
          end
        end
        sirq_pkg::SIRQ_START: begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == sirq_pkg::START_CLKS) begin
            st_reg <= sirq_pkg::SIRQ_RECOVER;
          end
        end
        sirq_pkg::SIRQ_RECOVER: st_reg <= sirq_pkg::SIRQ_TURN;
        sirq_pkg::SIRQ_TURN: begin
          st_reg    <= sirq_pkg::SIRQ_FRAME;
          phase_reg <= 2'h0;
          frame_reg <= 5'h00;
        end
        sirq_pkg::SIRQ_FRAME: begin
          if (phase_reg == sirq_pkg::LAST_PHASE) begin
            phase_reg <= 2'h0;
            if (frame_reg == sirq_pkg::FRAME_COUNT - 5'h01) begin
              st_reg  <= sirq_pkg::SIRQ_STOP;
              cnt_reg <= 3'h1;
            end else begin
              frame_reg <= frame_reg + 5'h01;
            end
          end else begin
            phase_reg <= phase_reg + 2'h1;
          end
        end
        sirq_pkg::SIRQ_STOP: begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == sirq_pkg::STOP_CLKS) begin
            st_reg <= sirq_pkg::SIRQ_STOP_REC;
          end
        end
        sirq_pkg::SIRQ_STOP_REC: st_reg <= sirq_pkg::SIRQ_IDLE;
        default:                 st_reg <= sirq_pkg::SIRQ_IDLE;
      endcase
    end
  end

  // Host drives start, stop and recovery; devices own the frames
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      serial_interrupt_line_oe  <= 1'b0;
      serial_interrupt_line_out <= 1'b1;
    end else begin
      serial_interrupt_line_oe  <= st_reg == sirq_pkg::SIRQ_START ||
                                   st_reg == sirq_pkg::SIRQ_RECOVER ||
                                   st_reg == sirq_pkg::SIRQ_STOP ||
                                   st_reg == sirq_pkg::SIRQ_STOP_REC;
      serial_interrupt_line_out <= st_reg == sirq_pkg::SIRQ_RECOVER ||
                                   st_reg == sirq_pkg::SIRQ_STOP_REC;
    end
  end

  // Check frame never sampled
  assign sample_pulse = pci_rise && st_reg == sirq_pkg::SIRQ_FRAME &&
                        phase_reg == 2'h0 &&
                        frame_reg < sirq_pkg::CHECK_FRAME;

  // ==========================================================
  // Interrupt detection; a device pulls the line low to report
  logic [15:0] level_reg;
  logic [15:0] level_new;
  logic [15:0] rise;
  logic [15:0] trigger;

  always_comb begin
    level_new = level_reg;
    if (sample_pulse) begin
      level_new[frame_reg[3:0]] = ~line_s;
    end
  end

  assign rise = level_new & ~level_reg;
  assign state_set = (edge_reg & rise) |
                     (~edge_reg & level_new & {16{sample_pulse}});
  assign trigger = (edge_reg & rise) |
                   (~edge_reg & state_set & ~state_reg);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      level_reg <= 16'h0000;
    end else begin
      level_reg <= level_new;
    end
  end

  // ==========================================================
  // Message sender
  logic [15:0] pending_reg;
  logic        valid_reg;
  logic [3:0]  msi_num_reg;
  logic [3:0]  pick;
  logic [3:0]  pick_num;
  logic        load;

  assign pick     = first_one(pending_reg);
  assign pick_num = pick & msg_mask(mmc_reg);
  assign load     = ~valid_reg & master_reg & single_message_enable_reg & (|pending_reg);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pending_reg <= 16'h0000;
    end else if (!single_message_enable_reg) begin
      pending_reg <= 16'h0000;
    end else begin
      pending_reg <= (pending_reg & ~(load ? 16'h0001 << pick : 16'h0000))
                     | trigger;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      valid_reg   <= 1'b0;
      msi_num_reg <= 4'h0;
      msi_addr    <= 64'h0;
      msi_is_64   <= 1'b0;
      msi_payload <= 32'h0000_0000;
    end else if (!single_message_enable_reg) begin
      valid_reg <= 1'b0;
    end else if (load) begin
      valid_reg   <= 1'b1;
      msi_num_reg <= pick_num;
      msi_addr    <= {addr_hi_reg, addr_lo_reg};
      msi_is_64   <= addr_hi_reg != 32'h0000_0000;
      msi_payload <= {16'h0000,
                      (msg_data_reg[15:4]),
                      (msg_data_reg[3:0] & ~msg_mask(mmc_reg)) |
                      pick_num};
    end else if (msi_req_valid && msi_req_ready) begin
      valid_reg <= 1'b0;
    end
  end

  // Held, not dropped, while bus mastering is off
  assign msi_req_valid = valid_reg & master_reg;

  // ==========================================================
  // Clock-run central resource (master only)
  logic strap_seen_reg;
  logic req_low;
  logic keep_alive;

  // Strap caught at the first edge after reset release, while sync_out still holds SYNC_IDLE, so always 1
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      strap_seen_reg <= 1'b0;
      strap_reg      <= 1'b0;
    end else if (!strap_seen_reg) begin
      strap_seen_reg <= 1'b1;
      strap_reg      <= strap_s;
    end
  end

  assign req_low    = strap_reg & ~gp0_s;
  assign keep_alive = (|state_reg) | ds_txn_req | valid_reg |
                      (st_reg != sirq_pkg::SIRQ_IDLE);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      clk_run_reg <= 1'b1;
      run_cnt_reg <= 10'h000;
    end else if (secondary_reset_control_reg || !strap_reg) begin
      clk_run_reg <= 1'b1;
      run_cnt_reg <= 10'h000;
    end else if (req_low) begin
      clk_run_reg <= 1'b1;
      run_cnt_reg <= sirq_pkg::CLK_RUN_MIN;
    end else if (clk_run_reg) begin
      if (run_cnt_reg != 10'h000) begin
        if (pci_rise) begin
          run_cnt_reg <= run_cnt_reg - 10'h001;
        end
      end else if (!keep_alive) begin
        clk_run_reg <= 1'b0;
      end
    end
  end

  // Only ever pulls the request line low; never answers as a slave
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      general_pin_zero_oe <= 1'b0;
    end else begin
      general_pin_zero_oe <= strap_reg & ~secondary_reset_control_reg & ~clk_run_reg &
                             ds_txn_req;
    end
  end

  assign general_pin_zero_out    = 1'b0;
  assign secondary_clock_running = clk_run_reg;

  // ==========================================================
  // Sideband lines, tracked on the local clock regardless of bus clocks
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      intx_asserted <= 4'h0;
      intx_change   <= 4'h0;
    end else begin
      intx_asserted <= ~intx_s;
      intx_change   <= ~intx_s ^ intx_asserted;
    end
  end

  // ==========================================================
  // Checks
  a_master_gate: assert property (@(posedge ref_clk) disable iff (reset)
    msi_req_valid |-> master_reg && single_message_enable_reg)
    else $error("message offered without bus mastering");
  a_enable_off: assert property (@(posedge ref_clk) disable iff (reset)
    !single_message_enable_reg |=> !valid_reg && pending_reg == 16'h0000)
    else $error("message kept while disabled");
  a_addr_width: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(valid_reg) |-> msi_is_64 == (msi_addr[63:32] != 32'h0))
    else $error("address width mismatch");
  a_msg_alias: assert property (@(posedge ref_clk) disable iff (reset)
    load |=> (msi_num_reg & ~msg_mask($past(mmc_reg))) == 4'h0 &&
             msi_payload[3:0] == ((msg_data_reg[3:0] &
             ~msg_mask($past(mmc_reg))) | msi_num_reg))
    else $error("message number not aliased");
  a_frame_range: assert property (@(posedge ref_clk) disable iff (reset)
    st_reg == sirq_pkg::SIRQ_FRAME |-> frame_reg < sirq_pkg::FRAME_COUNT)
    else $error("frame index past seventeen");
  a_check_skip: assert property (@(posedge ref_clk) disable iff (reset)
    sample_pulse |-> frame_reg != sirq_pkg::CHECK_FRAME)
    else $error("check frame sampled");
  a_hold_clock: assert property (@(posedge ref_clk) disable iff (reset)
    (|state_reg) && clk_run_reg |=> clk_run_reg)
    else $error("clocks stopped with interrupt pending");
  a_restart_min: assert property (@(posedge ref_clk) disable iff (reset)
    req_low && !secondary_reset_control_reg |=> clk_run_reg &&
    run_cnt_reg == sirq_pkg::CLK_RUN_MIN)
    else $error("request did not restart clocks");
  a_reset_run: assert property (@(posedge ref_clk) disable iff (reset)
    secondary_reset_control_reg |=> clk_run_reg && !secondary_bus_reset_n)
    else $error("clocks not running in secondary reset");
  a_status_read: assert property (@(posedge ref_clk) disable iff (reset)
    cfg_rd && cfg_addr == sirq_pkg::OFS_CLK_RUN_STAT |=>
    cfg_rdata[0] == $past(clk_run_reg))
    else $error("clock status read wrong");
  a_intx_track: assert property (@(posedge ref_clk) disable iff (reset)
    (~intx_s != intx_asserted) |=> intx_change != 4'h0)
    else $error("sideband change missed");

  c_msi_sent: cover property (@(posedge ref_clk) disable iff (reset)
    msi_req_valid && msi_req_ready && msi_is_64);
  c_clock_stop: cover property (@(posedge ref_clk) disable iff (reset)
    $fell(clk_run_reg));
  c_wake_req: cover property (@(posedge ref_clk) disable iff (reset)
    general_pin_zero_oe ##[1:40] clk_run_reg);

endmodule

// ---- test/sirq_irq_device.sv ----
// Bus device model: serial interrupt frames and clock requests
`timescale 1ns/1ps
module sirq_irq_device (
  input  wire logic        pci_clk,
  input  wire logic        line,
  input  wire logic        clocks_running,
  input  wire logic [16:0] irq_set,
  output logic             pull_low,
  output logic             clk_req
);
  int   lows   = 0;
  int   pos    = 0;
  logic active = 1'b0;
  initial pull_low = 1'b0;
  // Start pulse is the only low run of 3 or more, so stop is not mistaken
  always @(posedge pci_clk) begin
    lows <= line ? 0 : lows + 1;
    if (line && lows >= 3) begin
      active <= 1'b1;
      pos    <= 0;
    end else if (active) begin
      pos <= pos + 1;
      if (pos == 52)
        active <= 1'b0;
    end
  end
  // Change at falling edge so the level is settled at the sample edge
  always @(negedge pci_clk) begin
    pull_low <= active && pos >= 1 && (pos - 1) % 3 == 0 &&
                (pos - 1) / 3 < 17 && irq_set[(pos - 1) / 3];
  end
  assign clk_req = |irq_set && !clocks_running;
endmodule

// ---- test/sirq_top_test.sv ----
// Self-checking bench for the serial interrupt and clock-run block
`timescale 1ns/1ps
module sirq_top_test;
  logic        ref_clk = 0, reset = 1, pci_clk = 0, cfg_wr = 0, cfg_rd = 0;
  logic [7:0]  cfg_addr = 8'h00;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, pay;
  logic        ds_txn_req = 0, msi_req_ready = 0, sl_out, sl_oe, gp_oe;
  logic        run, rst_n, vld, is64, pull, creq;
  logic [3:0]  intx_n = 4'hF, iasr, ichg;
  logic [16:0] irq_set = 17'h0;
  logic [63:0] maddr;
  int          err_total = 0, compares = 0, n;
  wire         sl = sl_oe ? sl_out : ~pull;
  wire         gp = ~(gp_oe | creq);
  sirq_top sirq_top_inst (.ref_clk, .reset, .cfg_addr, .cfg_wr, .cfg_rd,
    .cfg_wdata, .cfg_rdata, .pci_clk_in(pci_clk),
    .serial_interrupt_line_in(sl), .serial_interrupt_line_out(sl_out),
    .serial_interrupt_line_oe(sl_oe), .general_pin_zero_in(gp),
    .general_pin_zero_out(), .general_pin_zero_oe(gp_oe),
    .clock_request_strap(1'b1), .intx_n, .ds_txn_req,
    .secondary_clock_running(run), .secondary_bus_reset_n(rst_n),
    .msi_req_valid(vld), .msi_req_ready, .msi_addr(maddr),
    .msi_is_64(is64), .msi_payload(pay), .intx_change(ichg),
    .intx_asserted(iasr));
  sirq_irq_device sirq_irq_device_inst (.pci_clk, .line(sl),
    .clocks_running(run), .irq_set, .pull_low(pull), .clk_req(creq));
  // ==========================================================
  // Access and compare tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1;
    @(negedge ref_clk);
    cfg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge ref_clk);
    cfg_addr = a;
    cfg_rd = 1;
    @(negedge ref_clk);
    cfg_rd = 0;
    @(negedge ref_clk);
    chk({32'h0, cfg_rdata}, {32'h0, e});
  endtask
  task automatic idle(input int c);
    repeat (c) @(negedge ref_clk);
  endtask
  task automatic until_run(input logic v);
    n = 0;
    while (run !== v && n < 12000) begin
      @(negedge ref_clk);
      n++;
    end
    chk({63'h0, run}, {63'h0, v});
  endtask
  task automatic msi(input logic [63:0] a, input logic b, input logic [15:0] p);
    int w;
    w = 0;
    while (vld !== 1'b1 && w < 3000) begin
      @(negedge ref_clk);
      w++;
    end
    chk({63'h0, vld}, 64'h1);
    chk(maddr, a);
    chk({63'h0, is64}, {63'h0, b});
    chk({48'h0, pay[15:0]}, {48'h0, p});
    msi_req_ready = 1;
    @(negedge ref_clk);
    msi_req_ready = 0;
  endtask
  task automatic none(input int c);
    int s;
    s = 0;
    repeat (c) begin
      @(negedge ref_clk);
      if (vld !== 1'b0) s++;
    end
    chk(s, 0);
  endtask
  task automatic quiet;
    irq_set = 17'h0;
    idle(600);
    wr(8'hE4, 32'hFFFF);
  endtask
  task automatic close_out;
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // Clocks, watchdog and test sequence
  initial forever #50 ref_clk = ~ref_clk;
  // Bus clock stands low while the block holds the clocks stopped
  initial begin
    #137;
    forever #400 pci_clk = run ? ~pci_clk : 1'b0;
  end
  initial begin
    #8000000;
    err_total++;
    close_out;
  end
  initial begin
    idle(12);
    reset = 0;
    rd(8'hDA, 32'h1);
    rd(8'h52, 32'h88);
    rd(8'h10, 32'h0);
    wr(8'h04, 32'h4);
    wr(8'h54, 32'hFEE0_0000);
    wr(8'h58, 32'h0);
    wr(8'h5C, 32'h1230);
    wr(8'h52, 32'h21);
    wr(8'hE0, 32'h1);
    wr(8'hE2, 32'hFFFF);
    irq_set = 17'h10020;
    msi(64'hFEE0_0000, 1'b0, 16'h1231);
    none(1500);
    rd(8'hE4, 32'h20);
    wr(8'h58, 32'h1);
    wr(8'hE2, 32'h0);
    for (int k = 0; k < 5; k++) begin
      quiet();
      wr(8'h52, 32'h1 | (k << 4));
      irq_set = 17'h8000;
      msi({32'h1, 32'hFEE0_0000}, 1'b1, 16'h1230 | ((1 << k) - 1));
    end
    quiet();
    wr(8'h04, 32'h0);
    irq_set = 17'h4;
    none(1200);
    wr(8'h04, 32'h4);
    msi({32'h1, 32'hFEE0_0000}, 1'b1, 16'h1232);
    quiet();
    wr(8'h52, 32'h0);
    irq_set = 17'h2;
    none(1200);
    rd(8'hE4, 32'h2);
    quiet();
    until_run(1'b0);
    rd(8'hDA, 32'h0);
    intx_n = 4'hE;
    idle(3);
    chk({60'h0, ichg}, 64'h1);
    idle(2);
    chk({60'h0, iasr}, 64'h1);
    irq_set = 17'h10000;
    until_run(1'b1);
    irq_set = 17'h0;
    until_run(1'b0);
    chk(n >= 4000, 1);
    ds_txn_req = 1;
    idle(2);
    chk({63'h0, gp_oe}, 64'h1);
    until_run(1'b1);
    ds_txn_req = 0;
    wr(8'h3E, 32'h40);
    idle(600);
    chk({62'h0, rst_n, run}, 64'h1);
    wr(8'h3E, 32'h0);
    idle(2);
    chk({63'h0, rst_n}, 64'h1);
    close_out;
  end
endmodule
